// [inc/maf_pkg.sv]
// Package holding register map, field layout and timing constants of the address filter block.
package maf_pkg;
	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [11:0] OFS_STATION_ADDRESS_UPPER = 12'h104;
	localparam logic [11:0] OFS_STATION_ADDRESS_LOWER = 12'h108;
	localparam logic [11:0] OFS_GROUP_HASH_UPPER = 12'h10c;
	localparam logic [11:0] OFS_GROUP_HASH_LOWER = 12'h110;
	localparam logic [11:0] OFS_PHY_MGMT_CONTROL = 12'h114;
	localparam logic [11:0] OFS_PHY_MGMT_VALUE = 12'h118;
	localparam logic [11:0] OFS_FILTER_CONTROL = 12'h128;
	// ==========================================================
	// Reset values
	localparam logic [15:0] RST_ADDR_UPPER = 16'hffff;
	localparam logic [31:0] RST_ADDR_LOWER = 32'hffffffff;
	localparam logic [31:0] RST_HASH = 32'h00000000;
	localparam logic [15:0] RST_MGMT_VALUE = 16'h0000;
	// ==========================================================
	// Field positions of the management control and filter control registers
	localparam int MC_PHYADDR_LSB = 11;
	localparam int MC_PHYADDR_MSB = 15;
	localparam int MC_INDEX_LSB = 6;
	localparam int MC_INDEX_MSB = 10;
	localparam int MC_DIR_BIT = 1;
	localparam int MC_BUSY_BIT = 0;
	localparam int FC_PASS_ALL_BIT = 0;
	// ==========================================================
	// Management frame constants
	localparam logic [1:0] MF_START = 2'b01;
	localparam logic [1:0] MF_OP_READ = 2'b10;
	localparam logic [1:0] MF_OP_WRITE = 2'b01;
	localparam logic [1:0] MF_TA_WRITE = 2'b10;
	localparam int MF_PREAMBLE_BITS = 32;
	localparam int MF_BODY_BITS = 32;
	// Body bit numbers of the first turnaround bit and the first data bit.
	localparam int MF_TA_FIRST = 14;
	localparam int MF_DATA_FIRST = 16;
	// Management clock: 2.5 MHz maximum, given as a period in ns.
	localparam int MDC_PERIOD_NS = 400;
	localparam int REF_CLK_NS = 4;
	localparam int MDC_HALF_CYCLES = (MDC_PERIOD_NS / 2 + REF_CLK_NS - 1) / REF_CLK_NS;
	// Pin synchroniser depth.
	localparam int SYNC_STAGES = 3;
	typedef enum logic [1:0] {MS_IDLE, MS_PRE, MS_BODY, MS_DONE} maf_mstate_e;
endpackage

// [hdl/maf_pin_sync.sv]
// Three-stage synchroniser that accepts a change when the last two stages agree.
`timescale 1ns/1ps
module maf_pin_sync
	import maf_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Pin and result.
	input wire logic pin,
	output logic level
);
	logic [SYNC_STAGES-1:0] stage;

	// ==========================================================
	// Shift chain; stage 0 feeds only stage 1.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stage <= '0;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], pin};
		end
	end

	// Filtered level only moves when stages two and three agree.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			level <= 1'b0;
		end else if (stage[SYNC_STAGES-1] == stage[SYNC_STAGES-2]) begin
			level <= stage[SYNC_STAGES-1];
		end
	end
endmodule

// [hdl/maf_mdc_div.sv]
// Divider that gives one-cycle enables for the management clock edges.
`timescale 1ns/1ps
module maf_mdc_div
	import maf_pkg::*;
#(
	parameter int HALF = MDC_HALF_CYCLES
)(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Control and enables.
	input wire logic run,
	output logic riseEn,
	output logic fallEn
);
	logic [7:0] count;
	logic phase;

	// ==========================================================
	// Count half periods while running; idle keeps the clock low.
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !run) begin
			count <= '0;
			phase <= 1'b0;
			riseEn <= 1'b0;
			fallEn <= 1'b0;
		end else if (count == 8'(HALF - 1)) begin
			count <= '0;
			phase <= ~phase;
			riseEn <= ~phase;
			fallEn <= phase;
		end else begin
			count <= count + 8'h01;
			riseEn <= 1'b0;
			fallEn <= 1'b0;
		end
	end
endmodule

// [hdl/maf_addr_filter.sv]
// Station address, group hash filter and PHY management access block.
`timescale 1ns/1ps
// Operation
// - Upper address holds bits 47:32, resets ones
// - Lower address holds bits 31:0, resets ones
// - Lower byte zero is first wire octet
// - Address registers survive core reset, protected reset clears them
// - Hash top bit picks word, five pick bit
// - Hash bit one accepts, zero rejects
// - Pass-all control accepts every group frame
// - Hash words read/write, reset to zero
// - Register index bits 10:6 choose PHY register
// - Bit 1 set writes, clear reads
// - Busy set by software, cleared on completion
// - Read result lands in the cycle busy clears
// - Data register sixteen bits, resets zero
module maf_addr_filter
	import maf_pkg::*;
#(
	parameter int HALF = MDC_HALF_CYCLES
)(
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic protRst_n,
	// Register port.
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdData,
	// Receive-side destination address check.
	input wire logic [47:0] rxDestAddr,
	input wire logic [5:0] rxHashIndex,
	input wire logic rxCheck,
	output logic rxStationMatch,
	output logic rxGroupAccept,
	output logic rxCheckDone,
	// PHY management pins.
	output logic mdc,
	output logic mdioOut,
	output logic mdioOe_n,
	input wire logic mdioIn
);
	// Register contents and frame engine state.
	logic [15:0] stationAddressUpper;
	logic [31:0] stationAddressLower;
	logic [31:0] groupHashUpper;
	logic [31:0] groupHashLower;
	logic [4:0] phyAddr;
	logic [4:0] phyRegIndex;
	logic phyMgmtDirection;
	logic phyMgmtBusy;
	logic [15:0] phyMgmtValue;
	logic passAllGroupFrames;
	logic wrHit;
	logic riseEn;
	logic fallEn;
	logic mdioSync;
	maf_mstate_e mState;
	logic [5:0] bitCount;
	logic [31:0] shiftOut;
	logic [15:0] shiftIn;
	logic doneStrobe;

	// Wire octet k of the station address, first octet is lower byte zero.
	function automatic logic [7:0] wire_octet(input logic [47:0] a, input int k);
		wire_octet = a[8*k +: 8];
	endfunction

	// Hash lookup over the two words selected by the index.
	function automatic logic hash_bit(input logic [31:0] hi, input logic [31:0] lo,
		input logic [5:0] idx);
		hash_bit = idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
	endfunction

	// Every write strobe is decoded in its own cycle; the port never stalls the master.
	// One name for the decode leaves room for a block select later.
	assign wrHit = regWr;

	// ==========================================================
	// Station address, kept through the core reset and cleared only by the protected reset.
	// Only sixteen upper bits exist, so bits 31:16 of that write are dropped.
	// Address storage.
	always_ff @(posedge ref_clk) begin
		if (!protRst_n) begin
			stationAddressUpper <= RST_ADDR_UPPER;
			stationAddressLower <= RST_ADDR_LOWER;
		end else if (wrHit && regAddr == OFS_STATION_ADDRESS_UPPER) begin
			stationAddressUpper <= regWrData[15:0];
		end else if (wrHit && regAddr == OFS_STATION_ADDRESS_LOWER) begin
			stationAddressLower <= regWrData;
		end
	end

	// ==========================================================
	// Group hash table and pass-all control.
	// The pass-all bit follows the core reset together with the hash words.
	// Hash words.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			groupHashUpper <= RST_HASH;
			groupHashLower <= RST_HASH;
			passAllGroupFrames <= 1'b0;
		end else if (wrHit) begin
			if (regAddr == OFS_GROUP_HASH_UPPER) begin
				groupHashUpper <= regWrData;
			end
			if (regAddr == OFS_GROUP_HASH_LOWER) begin
				groupHashLower <= regWrData;
			end
			if (regAddr == OFS_FILTER_CONTROL) begin
				passAllGroupFrames <= regWrData[FC_PASS_ALL_BIT];
			end
		end
	end

	// ==========================================================
	// Receive filter results, one cycle after the check strobe.
	// Both answers use the registers as they stood before a write in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rxStationMatch <= 1'b0;
			rxGroupAccept <= 1'b0;
			rxCheckDone <= 1'b0;
		end else begin
			rxCheckDone <= rxCheck;
			if (rxCheck) begin
				rxStationMatch <= 1'b1;
				for (int k = 0; k < 6; k++) begin
					if (wire_octet(rxDestAddr, k) !=
						wire_octet({stationAddressUpper, stationAddressLower}, k)) begin
						rxStationMatch <= 1'b0;
					end
				end
				rxGroupAccept <= passAllGroupFrames ||
					hash_bit(groupHashUpper, groupHashLower, rxHashIndex);
			end
		end
	end

	// ==========================================================
	// Management control register; busy is held by the engine.
	// Writes while busy are dropped so an access in flight cannot be corrupted.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phyAddr <= '0;
			phyRegIndex <= '0;
			phyMgmtDirection <= 1'b0;
			phyMgmtBusy <= 1'b0;
		end else if (doneStrobe) begin
			phyMgmtBusy <= 1'b0;
		end else if (wrHit && regAddr == OFS_PHY_MGMT_CONTROL && !phyMgmtBusy) begin
			// The PHY address is kept as written; software must write one.
			// Capture index and direction.
			phyAddr <= regWrData[MC_PHYADDR_MSB:MC_PHYADDR_LSB];
			phyRegIndex <= regWrData[MC_INDEX_MSB:MC_INDEX_LSB];
			phyMgmtDirection <= regWrData[MC_DIR_BIT];
			phyMgmtBusy <= regWrData[MC_BUSY_BIT];
		end
	end

	// ==========================================================
	// Management data register: software writes or read result.
	// Result stored with the busy clear.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			phyMgmtValue <= RST_MGMT_VALUE;
		end else if (doneStrobe && !phyMgmtDirection) begin
			phyMgmtValue <= shiftIn;
		end else if (wrHit && regAddr == OFS_PHY_MGMT_VALUE && !phyMgmtBusy) begin
			phyMgmtValue <= regWrData[15:0];
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the read strobe.
	// Unmapped offsets fall into the default branch.
	// Reserved bits and unmapped offsets read zero.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regRdData <= '0;
		end else if (regRd) begin
			unique case (regAddr)
				OFS_STATION_ADDRESS_UPPER: regRdData <= {16'h0000, stationAddressUpper};
				OFS_STATION_ADDRESS_LOWER: regRdData <= stationAddressLower;
				OFS_GROUP_HASH_UPPER: regRdData <= groupHashUpper;
				OFS_GROUP_HASH_LOWER: regRdData <= groupHashLower;
				OFS_PHY_MGMT_CONTROL: regRdData <= {16'h0000, phyAddr, phyRegIndex,
					4'h0, phyMgmtDirection, phyMgmtBusy};
				OFS_PHY_MGMT_VALUE: regRdData <= {16'h0000, phyMgmtValue};
				OFS_FILTER_CONTROL: regRdData <= {31'h0, passAllGroupFrames};
				default: regRdData <= '0;
			endcase
		end
	end

	// ==========================================================
	// Management clock divider and data pin synchroniser.
	// The divider only runs inside a frame, so the management clock rests low between accesses.
	maf_mdc_div #(.HALF(HALF)) u_div (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(mState == MS_PRE || mState == MS_BODY),
		.riseEn(riseEn),
		.fallEn(fallEn)
	);

	maf_pin_sync u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(mdioIn),
		.level(mdioSync)
	);

	// ==========================================================
	// Clause 22 frame engine: preamble, then 32 body bits shifted out on the falling edge.
	// Read data is sampled on the rising edge during the last sixteen bits.
	// The pin synchroniser delays a returned bit by four cycles, so HALF must be
	// five or more, or the rising edge would still see the previous bit.
	// Preamble and body share one bit counter to keep the sequencer small.
	// Frame sequencing.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mState <= MS_IDLE;
			bitCount <= '0;
			shiftOut <= '0;
			shiftIn <= '0;
			mdc <= 1'b0;
			mdioOut <= 1'b1;
			mdioOe_n <= 1'b1;
			doneStrobe <= 1'b0;
		end else begin
			doneStrobe <= 1'b0;
			if (riseEn) begin
				mdc <= 1'b1;
			end
			if (fallEn) begin
				mdc <= 1'b0;
			end
			unique case (mState)
				MS_IDLE: begin
					mdioOe_n <= 1'b1;
					mdioOut <= 1'b1;
					// The frame image is latched once, so later writes cannot alter it.
					if (phyMgmtBusy && !doneStrobe) begin
						mState <= MS_PRE;
						bitCount <= '0;
						mdioOe_n <= 1'b0;
						shiftOut <= {MF_START,
							phyMgmtDirection ? MF_OP_WRITE : MF_OP_READ,
							phyAddr, phyRegIndex, MF_TA_WRITE, phyMgmtValue};
					end
				end
				MS_PRE: begin
					// Preamble bits are ones, which mdioOut already shows.
					if (fallEn) begin
						if (bitCount == 6'(MF_PREAMBLE_BITS - 1)) begin
							mState <= MS_BODY;
							bitCount <= '0;
							mdioOut <= shiftOut[31];
							shiftOut <= {shiftOut[30:0], 1'b0};
						end else begin
							bitCount <= bitCount + 6'h01;
						end
					end
				end
				MS_BODY: begin
					if (fallEn) begin
						bitCount <= bitCount + 6'h01;
						mdioOut <= shiftOut[31];
						shiftOut <= {shiftOut[30:0], 1'b0};
						// Release the pin for turnaround and data on reads.
						// The first turnaround bit is left undriven so both ends never fight.
						if (!phyMgmtDirection && bitCount == 6'(MF_TA_FIRST - 1)) begin
							mdioOe_n <= 1'b1;
						end
						if (bitCount == 6'(MF_BODY_BITS - 1)) begin
							mState <= MS_DONE;
							mdioOe_n <= 1'b1;
						end
					end
					// Collect all sixteen read bits, first data bit included.
					if (riseEn && bitCount >= 6'(MF_DATA_FIRST)) begin
						shiftIn <= {shiftIn[14:0], mdioSync};
					end
				end
				MS_DONE: begin
					// One spare cycle, then busy clears with the result in place.
					mState <= MS_IDLE;
					doneStrobe <= 1'b1;
				end
			endcase
		end
	end
endmodule

// [verif/maf_phy_model.sv]
// Behavioural PHY answering management frames on the pins.
`timescale 1ns/1ps
module maf_phy_model (
	// Management pins.
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe_n,
	output logic mdioIn,
	// Bench side.
	input wire logic [15:0] rdVal,
	output logic [15:0] lastWr,
	output logic [4:0] lastIdx
);
	logic [15:0] sh = 16'hffff;
	logic rd = 1'b0;
	logic drv = 1'b0;
	int left = 0;
	int rc = 0;
	// A released line shows the inverse of the last bit, so stale data never passes.
	assign mdioIn = !mdioOe_n ? mdioOut : (rd ? drv : !drv);
	// Decode start, opcode, PHY address and index after the preamble.
	always @(posedge mdc) begin
		sh = {sh[14:0], mdioOut};
		if (left > 0) begin
			left--;
			if (left == 0 && !rd) lastWr = sh;
			if (left == 0) sh = 16'hffff;
		end else if (!mdioOe_n && sh[13:12] == 2'b01 && sh[9:5] == 5'h01) begin
			lastIdx = sh[4:0];
			rd = (sh[11:10] == 2'b10);
			rc = 0;
			left = 18;
		end
	end
	// Turnaround and read data go out on the falling edge.
	always @(negedge mdc) begin
		if (rd) begin
			rc++;
			if (rc > 18) rd = 1'b0;
			else drv = (rc == 1) ? 1'b1 : (rc == 2) ? 1'b0 : rdVal[18 - rc];
		end
	end
endmodule

// [verif/maf_addr_filter_asserts.sv]
// Concurrent checks on the ports of the address filter block.
`timescale 1ns/1ps
module maf_addr_filter_asserts
	import maf_pkg::*;
#(
	parameter int HALF = MDC_HALF_CYCLES
)(
	// Clock and resets.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic protRst_n,
	// Register port.
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	// Address check.
	input wire logic [47:0] rxDestAddr,
	input wire logic [5:0] rxHashIndex,
	input wire logic rxCheck,
	input wire logic rxStationMatch,
	input wire logic rxGroupAccept,
	input wire logic rxCheckDone,
	// Management pins.
	input wire logic mdc,
	input wire logic mdioOut,
	input wire logic mdioOe_n,
	input wire logic mdioIn
);
	logic [15:0] aHi;
	logic [31:0] aLo, hHi, hLo;
	logic passAll, mdcQ, expAcc;
	int hcnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ==========
	// Shadows
	// Station address survives the core reset, so only the protected reset clears it.
	always_ff @(posedge ref_clk) begin
		if (!protRst_n) begin
			aHi <= RST_ADDR_UPPER;
			aLo <= RST_ADDR_LOWER;
		end else if (regWr && regAddr == OFS_STATION_ADDRESS_UPPER) aHi <= regWrData[15:0];
		else if (regWr && regAddr == OFS_STATION_ADDRESS_LOWER) aLo <= regWrData;
	end
	// Hash words and pass-all flag follow the core reset.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hHi <= RST_HASH;
			hLo <= RST_HASH;
			passAll <= 1'b0;
		end else if (regWr) begin
			if (regAddr == OFS_GROUP_HASH_UPPER) hHi <= regWrData;
			if (regAddr == OFS_GROUP_HASH_LOWER) hLo <= regWrData;
			if (regAddr == OFS_FILTER_CONTROL) passAll <= regWrData[FC_PASS_ALL_BIT];
		end
	end
	// Cycles spent at the current management clock level.
	always_ff @(posedge ref_clk) begin
		mdcQ <= mdc;
		hcnt <= (mdc != mdcQ) ? 1 : hcnt + 1;
	end
	assign expAcc = passAll | (rxHashIndex[5] ? hHi[rxHashIndex[4:0]] : hLo[rxHashIndex[4:0]]);
	// ==========
	// Assertions
	a_reset_idle: assert property (
		disable iff (1'b0) !rst_n |=> regRdData == 32'h0 && !mdc && mdioOe_n)
		else $error("outputs not idle after reset");
	a_upper_read: assert property (
		regRd && regAddr == OFS_STATION_ADDRESS_UPPER |=> regRdData == {16'h0000, aHi})
		else $error("upper address readback wrong");
	a_hash_read: assert property (
		regRd && regAddr == OFS_GROUP_HASH_UPPER |=> regRdData == hHi)
		else $error("hash upper readback wrong");
	a_unmapped_zero: assert property (
		regRd && regAddr == 12'h100 |=> regRdData == 32'h0)
		else $error("unmapped read not zero");
	a_station_hit: assert property (
		rxCheck |=> rxStationMatch == ($past(rxDestAddr) == {$past(aHi), $past(aLo)}))
		else $error("station match wrong");
	a_group_accept: assert property (
		rxCheck |=> rxGroupAccept == $past(expAcc))
		else $error("group accept wrong");
	a_done_pulse: assert property (
		rxCheckDone == $past(rxCheck))
		else $error("check done not one cycle after request");
	a_mdc_half: assert property (
		$fell(mdc) |-> hcnt == HALF)
		else $error("management clock high phase wrong");
	c_accept: cover property (rxCheckDone && rxGroupAccept);
	c_station: cover property (rxCheckDone && rxStationMatch);
	c_release: cover property (mdioOe_n && mdc);
endmodule

// [verif/test_maf_addr_filter.sv]
// Self-checking bench of the address filter block.
`timescale 1ns/1ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin nFail++; $display("mismatch %0t got %h want %h", $time, a, e); end end
module test_maf_addr_filter
	import maf_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic protRst_n = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWrData = 32'h0, regRdData, d;
	logic regWr = 1'b0, regRd = 1'b0, rxCheck = 1'b0;
	logic [47:0] rxDestAddr = 48'h0;
	logic [5:0] rxHashIndex = 6'h00;
	logic rxStationMatch, rxGroupAccept, rxCheckDone, mdc, mdioOut, mdioOe_n, mdioIn;
	logic [15:0] rdVal = 16'h3c5a, lastWr;
	logic [4:0] lastIdx;
	int nFail = 0, checksDone = 0, cyc = 0;
	// Short management clock keeps each frame near a thousand cycles.
	// Eight cycles per half period leave room for the four-cycle pin synchroniser.
	maf_addr_filter #(.HALF(8)) maf_addr_filter_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .protRst_n(protRst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData),
		.rxDestAddr(rxDestAddr), .rxHashIndex(rxHashIndex), .rxCheck(rxCheck),
		.rxStationMatch(rxStationMatch), .rxGroupAccept(rxGroupAccept),
		.rxCheckDone(rxCheckDone),
		.mdc(mdc), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .mdioIn(mdioIn)
	);
	maf_phy_model maf_phy_model_inst (
		.mdc(mdc), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .mdioIn(mdioIn),
		.rdVal(rdVal), .lastWr(lastWr), .lastIdx(lastIdx)
	);
	always #2 ref_clk = ~ref_clk;
	// A hung access is cut short here.
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			nFail++;
			completeRun;
		end
	end
	// ==========
	// Bus tasks
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		regAddr <= a;
		regWrData <= v;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [11:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		d = regRdData;
		@(posedge ref_clk);
	endtask
	task automatic chk(input logic [47:0] a, input logic [5:0] i, input logic m, input logic g);
		rxDestAddr <= a;
		rxHashIndex <= i;
		rxCheck <= 1'b1;
		@(posedge ref_clk);
		rxCheck <= 1'b0;
		@(negedge ref_clk);
		`CHK(rxStationMatch, m)
		`CHK(rxGroupAccept, g)
		`CHK(rxCheckDone, 1'b1)
		@(posedge ref_clk);
	endtask
	// Polls the busy flag under a bound, then checks reserved control bits.
	// Busy clear first.
	task automatic idle;
		int n;
		n = 0;
		d = 32'h1;
		while (d[0] !== 1'b0 && n < 1000) begin
			rd(OFS_PHY_MGMT_CONTROL);
			n++;
		end
		`CHK(d[0], 1'b0)
		`CHK(d & 32'hffff003c, 32'h0)
	endtask
	// ==========
	// Scenarios
	task automatic t_reset_regs;
		rd(OFS_STATION_ADDRESS_UPPER);
		`CHK(d, 32'h0000ffff)
		rd(OFS_STATION_ADDRESS_LOWER);
		`CHK(d, 32'hffffffff)
		rd(OFS_GROUP_HASH_LOWER);
		`CHK(d, 32'h0)
		rd(OFS_PHY_MGMT_VALUE);
		`CHK(d, 32'h0)
		rd(12'h100);
		`CHK(d, 32'h0)
	endtask
	task automatic t_station;
		wr(OFS_STATION_ADDRESS_UPPER, 32'hffffbc9a);
		wr(OFS_STATION_ADDRESS_LOWER, 32'h78563412);
		rd(OFS_STATION_ADDRESS_UPPER);
		`CHK(d, 32'h0000bc9a)
		chk(48'hbc9a78563412, 6'h00, 1'b1, 1'b0);
		chk(48'hbd9a78563412, 6'h00, 1'b0, 1'b0);
	endtask
	task automatic t_hash;
		wr(OFS_GROUP_HASH_UPPER, 32'h80000001);
		wr(OFS_GROUP_HASH_LOWER, 32'h00000002);
		rd(OFS_GROUP_HASH_UPPER);
		`CHK(d, 32'h80000001)
		chk(48'h0, 6'h3f, 1'b0, 1'b1);
		chk(48'h0, 6'h20, 1'b0, 1'b1);
		chk(48'h0, 6'h01, 1'b0, 1'b1);
		chk(48'h0, 6'h00, 1'b0, 1'b0);
		chk(48'h0, 6'h21, 1'b0, 1'b0);
		wr(OFS_FILTER_CONTROL, 32'h1);
		chk(48'h0, 6'h00, 1'b0, 1'b1);
		wr(OFS_FILTER_CONTROL, 32'h0);
	endtask
	// Core reset alone keeps the station address and clears the hash words.
	task automatic t_core_reset;
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(OFS_STATION_ADDRESS_LOWER);
		`CHK(d, 32'h78563412)
		rd(OFS_GROUP_HASH_UPPER);
		`CHK(d, 32'h0)
		protRst_n <= 1'b0;
		@(posedge ref_clk);
		protRst_n <= 1'b1;
		@(posedge ref_clk);
		rd(OFS_STATION_ADDRESS_UPPER);
		`CHK(d, 32'h0000ffff)
		rd(OFS_STATION_ADDRESS_LOWER);
		`CHK(d, 32'hffffffff)
	endtask
	// A write of the value register while busy must be ignored.
	task automatic t_phy_write;
		wr(OFS_PHY_MGMT_VALUE, 32'h0000a5c3);
		wr(OFS_PHY_MGMT_CONTROL, 32'h00000a83);
		rd(OFS_PHY_MGMT_CONTROL);
		`CHK(d[0], 1'b1)
		wr(OFS_PHY_MGMT_VALUE, 32'h00001111);
		idle;
		`CHK(lastWr, 16'ha5c3)
		`CHK(lastIdx, 5'h0a)
		rd(OFS_PHY_MGMT_VALUE);
		`CHK(d, 32'h0000a5c3)
	endtask
	task automatic t_phy_read;
		wr(OFS_PHY_MGMT_CONTROL, 32'h00000d41);
		idle;
		`CHK(lastIdx, 5'h15)
		rd(OFS_PHY_MGMT_VALUE);
		`CHK(d, 32'h00003c5a)
	endtask
	task automatic completeRun;
		if (nFail == 0 && checksDone > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		protRst_n <= 1'b1;
		@(posedge ref_clk);
		t_reset_regs;
		t_station;
		t_hash;
		t_core_reset;
		t_phy_write;
		t_phy_read;
		completeRun;
	end
endmodule
bind maf_addr_filter maf_addr_filter_asserts #(.HALF(HALF)) maf_addr_filter_asserts_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .protRst_n(protRst_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData),
	.rxDestAddr(rxDestAddr), .rxHashIndex(rxHashIndex), .rxCheck(rxCheck),
	.rxStationMatch(rxStationMatch), .rxGroupAccept(rxGroupAccept),
	.rxCheckDone(rxCheckDone),
	.mdc(mdc), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .mdioIn(mdioIn)
);
